// ---- core/ums_regs.svh ----
`ifndef UMS_REGS_SVH
`define UMS_REGS_SVH

// Byte addresses of the registers on the plain register port.
`define UMS_MODEM_LINE_STATUS_ADDR 32'h5000_1118
`define UMS_SPARE_STORAGE_ADDR 32'h5000_111C
`define UMS_ALIAS_FIRST_ADDR 32'h5000_1130
`define UMS_ALIAS_LAST_ADDR 32'h5000_116C
`define UMS_MODEM_CONTROL_ADDR 32'h5000_1180
`define UMS_LINE_STATUS_ADDR 32'h5000_1184

// Modem line status fields.
`define UMS_CTS_BIT 4
`define UMS_PEER_CHANGED_BIT 0

// Modem control fields.
`define UMS_FIFO_EN_BIT 0
`define UMS_RTS_BIT 1
`define UMS_LOOP_BIT 4
`define UMS_IR_MODE_BIT 6

// Line status fields.
`define UMS_RX_AVAIL_BIT 0
`define UMS_OVERRUN_BIT 1
`define UMS_TX_EMPTY_BIT 5
`define UMS_TX_IDLE_BIT 6
`define UMS_TX_FULL_BIT 7

// Reset values.
`define UMS_REG_RESET 16'h0000
`define UMS_LINE_IDLE 1'h1

// Queue depth and serial timing.
`define UMS_FIFO_DEPTH 5'h10
`define UMS_OVS_DIV 8'h36
`define UMS_TICKS_LAST 4'hF
`define UMS_IR_PULSE 4'h3

`endif

// ---- core/ums_pkg.sv ----
package ums_pkg;

   // Transmit serialiser states.
   typedef enum logic [1:0] {
      UMS_TX_IDLE = 2'b00,
      UMS_TX_START = 2'b01,
      UMS_TX_DATA = 2'b10,
      UMS_TX_STOP = 2'b11
   } ums_tx_e;

   typedef logic [7:0] ums_byte_t;

   // One register port access.
   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } ums_bus_s;

   // Software controlled modem and queue settings.
   typedef struct packed {
      logic ir_mode;
      logic loop;
      logic rts;
      logic fifo_en;
   } ums_ctrl_s;

   // Whole state of the block.
   typedef struct packed {
      logic cts_s1;
      logic cts_s2;
      logic cts_prev;
      logic peer_changed;
      ums_ctrl_s ctrl;
      ums_byte_t spare;
      logic [15:0][7:0] rx_mem;
      logic [3:0] rx_rd;
      logic [3:0] rx_wr;
      logic [4:0] rx_cnt;
      logic overrun;
      logic [15:0][7:0] tx_mem;
      logic [3:0] tx_rd;
      logic [3:0] tx_wr;
      logic [4:0] tx_cnt;
      ums_tx_e tx_st;
      logic [7:0] ovs_cnt;
      logic [3:0] tick_cnt;
      logic [2:0] bit_idx;
      ums_byte_t tx_sh;
      logic tx_line;
      logic ir_b;
      logic [15:0] rdata;
   } ums_state_s;

endpackage : ums_pkg

// ---- core/ums_core.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ums_regs.svh"

// What this block does
// - Clear-to-send status is inverted peer ready pin.
// - Loopback reports clear-to-send from request-to-send bit.
// - Peer ready toggle sets the changed flag.
// - Reading modem status clears the changed flag.
// - Loopback changed flag follows request-to-send toggles.
// - Pin held low through reset sets flag.
// - Spare byte register, resets zero, no effect.
// - Sixteen word aliases reach receive and transmit.
// - Alias read returns received byte, valid when flagged.
// - Non-queue receive overwrites unread byte, flags overrun.
// - Queue mode alias read pops oldest entry.
// - Full receive queue drops arrival, flags overrun.
// - Non-queue write clears transmit holding empty flag.
// - Non-queue repeat writes replace the held byte.
// - Queue mode accepts sixteen writes before full.
// - Write to full transmit queue is discarded.
// - Serialise onto wired or active-low infrared output.
// - Receive flag clears when buffer or queue empties.
module ums_core (
   input wire logic I_CORE_CLK,
   input wire logic I_RST_B,
   input wire logic [31:0] I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [15:0] O_RDATA,
   input wire logic I_CTS_B,
   input wire logic I_RX_STB,
   input wire logic [7:0] I_RX_DATA,
   output logic O_TX,
   output logic O_IR_TX_B,
   output logic O_RTS_B,
   output logic O_RX_AVAIL,
   output logic O_TX_EMPTY,
   output logic O_FIFO_EN
);

   ums_pkg::ums_state_s q;
   ums_pkg::ums_state_s d;
   ums_pkg::ums_bus_s bus;
   logic cts_now;
   logic mls_rd;
   logic spare_wr;
   logic spare_rd;
   logic ctrl_wr;
   logic alias_rd;
   logic alias_wr;
   logic rx_pop;
   logic tick;
   logic cur_bit;
   ums_pkg::ums_byte_t rx_head;

   // Alias decode is used for both the read and the write side.
   function automatic logic is_alias(input logic [31:0] addr);
      is_alias = (addr >= `UMS_ALIAS_FIRST_ADDR) && (addr <= `UMS_ALIAS_LAST_ADDR) && (addr[1:0] == 2'h0);
   endfunction : is_alias

   // Register port decode; strobes never come together.
   assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
   assign mls_rd = bus.rd && (bus.addr == `UMS_MODEM_LINE_STATUS_ADDR);
   assign spare_wr = bus.wr && (bus.addr == `UMS_SPARE_STORAGE_ADDR);
   assign spare_rd = bus.rd && (bus.addr == `UMS_SPARE_STORAGE_ADDR);
   assign ctrl_wr = bus.wr && (bus.addr == `UMS_MODEM_CONTROL_ADDR);
   assign alias_rd = bus.rd && is_alias(bus.addr);
   assign alias_wr = bus.wr && is_alias(bus.addr);
   assign rx_pop = alias_rd && (q.rx_cnt != 5'h00);
   assign rx_head = q.rx_mem[q.rx_rd];

   // Only the second synchroniser stage is looked at; loopback swaps in the control bit.
   assign cts_now = q.ctrl.loop ? q.ctrl.rts : ~q.cts_s2;

   // The oversampling tick is a one-cycle enable, sixteen of them per bit.
   assign tick = (q.ovs_cnt == (`UMS_OVS_DIV - 8'h01));

   // Level the serialiser wants on the line now; idle and stop are high.
   assign cur_bit = (q.tx_st == ums_pkg::UMS_TX_START) ? 1'h0 :
                    (q.tx_st == ums_pkg::UMS_TX_DATA) ? q.tx_sh[0] : 1'h1;

   // Next-state logic for the whole block.
   always_comb begin
      d = q;
      d.rdata = `UMS_REG_RESET;

      // Peer ready pin: two flops, then change detection against the last seen level.
      d.cts_s1 = I_CTS_B;
      d.cts_s2 = q.cts_s1;
      d.cts_prev = cts_now;
      if (mls_rd) begin
         d.peer_changed = 1'h0;
      end
      // A change in the same cycle as the read wins so no edge is lost.
      if (cts_now != q.cts_prev) begin
         d.peer_changed = 1'h1;
      end

      // Software writes to spare storage and modem control.
      if (spare_wr) begin
         d.spare = bus.wdata[7:0];
      end
      if (ctrl_wr) begin
         d.ctrl.fifo_en = bus.wdata[`UMS_FIFO_EN_BIT];
         d.ctrl.rts = bus.wdata[`UMS_RTS_BIT];
         d.ctrl.loop = bus.wdata[`UMS_LOOP_BIT];
         d.ctrl.ir_mode = bus.wdata[`UMS_IR_MODE_BIT];
         // Changing queue mode flushes both queues, so old pointers never leak across modes.
         if (bus.wdata[`UMS_FIFO_EN_BIT] != q.ctrl.fifo_en) begin
            d.rx_cnt = 5'h00;
            d.rx_rd = 4'h0;
            d.rx_wr = 4'h0;
            d.tx_cnt = 5'h00;
            d.tx_rd = 4'h0;
            d.tx_wr = 4'h0;
         end
      end

      // Receive side: a read of any alias takes the head entry out.
      if (rx_pop) begin
         d.rx_rd = q.rx_rd + 4'h1;
         d.rx_cnt = q.rx_cnt - 5'h01;
      end
      // Overrun is cleared by reading line status; a new overrun in that cycle still sets it.
      if (bus.rd && (bus.addr == `UMS_LINE_STATUS_ADDR)) begin
         d.overrun = 1'h0;
      end
      if (I_RX_STB && !(ctrl_wr && (bus.wdata[`UMS_FIFO_EN_BIT] != q.ctrl.fifo_en))) begin
         if (!q.ctrl.fifo_en) begin
            // Single buffer: the new byte always lands, an unread one is lost.
            if ((q.rx_cnt != 5'h00) && !rx_pop) begin
               d.overrun = 1'h1;
            end
            d.rx_mem[d.rx_rd] = I_RX_DATA;
            d.rx_wr = d.rx_rd + 4'h1;
            d.rx_cnt = 5'h01;
         end else if (d.rx_cnt == `UMS_FIFO_DEPTH) begin
            d.overrun = 1'h1;
         end else begin
            d.rx_mem[q.rx_wr] = I_RX_DATA;
            d.rx_wr = q.rx_wr + 4'h1;
            d.rx_cnt = d.rx_cnt + 5'h01;
         end
      end

      // Serialiser: the divider runs freely, frames follow its ticks.
      d.ovs_cnt = tick ? 8'h00 : q.ovs_cnt + 8'h01;
      case (q.tx_st)
         ums_pkg::UMS_TX_IDLE: begin
            if ((q.tx_cnt != 5'h00) && !(ctrl_wr && (bus.wdata[`UMS_FIFO_EN_BIT] != q.ctrl.fifo_en))) begin
               d.tx_sh = q.tx_mem[q.tx_rd];
               d.tx_rd = q.tx_rd + 4'h1;
               d.tx_cnt = q.tx_cnt - 5'h01;
               d.tick_cnt = 4'h0;
               d.tx_st = ums_pkg::UMS_TX_START;
            end
         end
         ums_pkg::UMS_TX_START: begin
            if (tick) begin
               d.tick_cnt = q.tick_cnt + 4'h1;
               if (q.tick_cnt == `UMS_TICKS_LAST) begin
                  d.bit_idx = 3'h0;
                  d.tx_st = ums_pkg::UMS_TX_DATA;
               end
            end
         end
         ums_pkg::UMS_TX_DATA: begin
            if (tick) begin
               d.tick_cnt = q.tick_cnt + 4'h1;
               if (q.tick_cnt == `UMS_TICKS_LAST) begin
                  d.tx_sh = {1'h0, q.tx_sh[7:1]};
                  d.bit_idx = q.bit_idx + 3'h1;
                  if (q.bit_idx == 3'h7) begin
                     d.tx_st = ums_pkg::UMS_TX_STOP;
                  end
               end
            end
         end
         ums_pkg::UMS_TX_STOP: begin
            if (tick) begin
               d.tick_cnt = q.tick_cnt + 4'h1;
               if (q.tick_cnt == `UMS_TICKS_LAST) begin
                  d.tx_st = ums_pkg::UMS_TX_IDLE;
               end
            end
         end
         default: begin
            d.tx_st = ums_pkg::UMS_TX_IDLE;
         end
      endcase

      // Transmit write after the serialiser has taken its byte, so both can happen at once.
      if (alias_wr && !(ctrl_wr)) begin
         if (!q.ctrl.fifo_en) begin
            // A byte still waiting is replaced rather than queued behind.
            if (d.tx_cnt != 5'h00) begin
               d.tx_mem[d.tx_rd] = bus.wdata[7:0];
            end else begin
               d.tx_mem[d.tx_wr] = bus.wdata[7:0];
               d.tx_wr = d.tx_wr + 4'h1;
            end
            d.tx_cnt = 5'h01;
         end else if (d.tx_cnt != `UMS_FIFO_DEPTH) begin
            d.tx_mem[d.tx_wr] = bus.wdata[7:0];
            d.tx_wr = d.tx_wr + 4'h1;
            d.tx_cnt = d.tx_cnt + 5'h01;
         end
         // A write to a full queue falls through and changes nothing.
      end

      // Line levels: infrared sends a short low pulse for each zero bit.
      d.tx_line = q.ctrl.ir_mode ? `UMS_LINE_IDLE : cur_bit;
      d.ir_b = ~(q.ctrl.ir_mode && !cur_bit && (q.tick_cnt < `UMS_IR_PULSE));

      // Read data stand only in the cycle after the read strobe.
      if (bus.rd) begin
         if (mls_rd) begin
            d.rdata[`UMS_CTS_BIT] = cts_now;
            d.rdata[`UMS_PEER_CHANGED_BIT] = q.peer_changed;
         end else if (spare_rd) begin
            d.rdata[7:0] = q.spare;
         end else if (alias_rd) begin
            d.rdata[7:0] = rx_head;
         end else if (bus.addr == `UMS_MODEM_CONTROL_ADDR) begin
            d.rdata[`UMS_FIFO_EN_BIT] = q.ctrl.fifo_en;
            d.rdata[`UMS_RTS_BIT] = q.ctrl.rts;
            d.rdata[`UMS_LOOP_BIT] = q.ctrl.loop;
            d.rdata[`UMS_IR_MODE_BIT] = q.ctrl.ir_mode;
         end else if (bus.addr == `UMS_LINE_STATUS_ADDR) begin
            d.rdata[`UMS_RX_AVAIL_BIT] = (q.rx_cnt != 5'h00);
            d.rdata[`UMS_OVERRUN_BIT] = q.overrun;
            d.rdata[`UMS_TX_EMPTY_BIT] = (q.tx_cnt == 5'h00);
            d.rdata[`UMS_TX_IDLE_BIT] = (q.tx_cnt == 5'h00) && (q.tx_st == ums_pkg::UMS_TX_IDLE);
            d.rdata[`UMS_TX_FULL_BIT] = (q.tx_cnt == `UMS_FIFO_DEPTH);
         end
      end
   end

   // State register. The pin flops reset to the idle level so a low pin shows up as a change.
   always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         q <= '0;
         q.cts_s1 <= `UMS_LINE_IDLE;
         q.cts_s2 <= `UMS_LINE_IDLE;
         q.tx_line <= `UMS_LINE_IDLE;
         q.ir_b <= `UMS_LINE_IDLE;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from state.
   assign O_RDATA = q.rdata;
   assign O_TX = q.tx_line;
   assign O_IR_TX_B = q.ir_b;
   assign O_RTS_B = ~(q.ctrl.rts && !q.ctrl.loop);
   assign O_RX_AVAIL = (q.rx_cnt != 5'h00);
   assign O_TX_EMPTY = (q.tx_cnt == 5'h00);
   assign O_FIFO_EN = q.ctrl.fifo_en;

   // Checks on the block's own behaviour.
   default clocking ums_cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!I_RST_B);

   a_cts_pin_inverse: assert property (
      (mls_rd && !q.ctrl.loop) |=> (O_RDATA[`UMS_CTS_BIT] == !$past(q.cts_s2)))
      else $error("clear-to-send status not the inverse of the pin");

   a_cts_loop_copy: assert property (
      (mls_rd && q.ctrl.loop) |=> (O_RDATA[`UMS_CTS_BIT] == $past(q.ctrl.rts)))
      else $error("loopback clear-to-send does not follow request-to-send");

   a_change_sets_flag: assert property (
      (cts_now != q.cts_prev) |=> q.peer_changed)
      else $error("peer ready change did not set the changed flag");

   a_read_clears_flag: assert property (
      (mls_rd && (cts_now == q.cts_prev)) |=> !q.peer_changed)
      else $error("modem status read did not clear the changed flag");

   a_loop_rts_toggle: assert property (
      (q.ctrl.loop && ctrl_wr && bus.wdata[`UMS_LOOP_BIT] && (bus.wdata[`UMS_RTS_BIT] != q.ctrl.rts)) |=> ##1 q.peer_changed)
      else $error("request-to-send toggle in loopback not flagged");

   a_pin_low_flag: assert property (
      ($fell(I_CTS_B) && !q.ctrl.loop) ##1 (!I_CTS_B && !q.ctrl.loop && !ctrl_wr) [*2] |=> q.peer_changed)
      else $error("peer ready pin going low was not flagged");

   a_spare_readback: assert property (
      spare_wr ##1 spare_rd |=> (O_RDATA == {8'h00, $past(I_WDATA[7:0], 2)}))
      else $error("spare byte does not read back");

   a_alias_head_pop: assert property (
      rx_pop |=> ((O_RDATA[7:0] == $past(rx_head)) && (q.rx_cnt == $past(q.rx_cnt) - 5'h01 + 5'($past(I_RX_STB) && !$past(ctrl_wr)) || !q.ctrl.fifo_en)))
      else $error("alias read did not return and pop the head entry");

   a_rx_overwrite: assert property (
      (I_RX_STB && !ctrl_wr && !q.ctrl.fifo_en && (q.rx_cnt != 5'h00) && !rx_pop) |=> (q.overrun && (q.rx_cnt == 5'h01)))
      else $error("single receive buffer did not overwrite with overrun");

   a_rx_full_drop: assert property (
      (I_RX_STB && !ctrl_wr && q.ctrl.fifo_en && (q.rx_cnt == `UMS_FIFO_DEPTH) && !rx_pop) |=>
      (q.overrun && $stable(q.rx_mem) && (q.rx_cnt == `UMS_FIFO_DEPTH)))
      else $error("full receive queue was altered by an arrival");

   a_tx_write_fills: assert property (
      (alias_wr && !q.ctrl.fifo_en && (q.tx_cnt == 5'h00)) |=> !O_TX_EMPTY)
      else $error("transmit write did not clear the empty flag");

   a_tx_replace: assert property (
      (alias_wr && !q.ctrl.fifo_en && (q.tx_cnt != 5'h00) && (q.tx_st != ums_pkg::UMS_TX_IDLE)) |=>
      ((q.tx_cnt == 5'h01) && (q.tx_mem[q.tx_rd] == $past(I_WDATA[7:0]))))
      else $error("repeat transmit write did not replace the held byte");

   a_tx_full_drop: assert property (
      (alias_wr && (q.tx_cnt == `UMS_FIFO_DEPTH) && (q.tx_st != ums_pkg::UMS_TX_IDLE)) |=> $stable(q.tx_mem))
      else $error("write to full transmit queue changed it");

   a_tx_start_low: assert property (
      ((q.tx_st == ums_pkg::UMS_TX_START) && !q.ctrl.ir_mode) |=> !O_TX)
      else $error("start bit not driven low on the wired output");

   a_rx_flag_empty: assert property (
      (rx_pop && (q.rx_cnt == 5'h01) && !I_RX_STB) |=> !O_RX_AVAIL)
      else $error("receive flag stayed set after the last byte was read");

   // Queue bounds and line idling; a counter past the depth would corrupt the ring pointers.
   a_rx_count_bound: assert property (
      q.rx_cnt <= `UMS_FIFO_DEPTH)
      else $error("receive count ran past the queue depth");

   a_tx_count_bound: assert property (
      q.tx_cnt <= `UMS_FIFO_DEPTH)
      else $error("transmit count ran past the queue depth");

   a_single_rx_depth: assert property (
      !q.ctrl.fifo_en |-> (q.rx_cnt <= 5'h01))
      else $error("single receive buffer holds more than one byte");

   a_single_tx_depth: assert property (
      !q.ctrl.fifo_en |-> (q.tx_cnt <= 5'h01))
      else $error("single transmit holding holds more than one byte");

   a_ir_wired_high: assert property (
      q.ctrl.ir_mode |=> O_TX)
      else $error("wired output moved while infrared mode was on");

   a_wired_ir_idle: assert property (
      !q.ctrl.ir_mode |=> O_IR_TX_B)
      else $error("infrared output pulsed while wired mode was on");

   a_rx_queue_avail: assert property (
      (I_RX_STB && !ctrl_wr && q.ctrl.fifo_en && (q.rx_cnt != `UMS_FIFO_DEPTH)) |=> O_RX_AVAIL)
      else $error("accepted receive byte did not raise the available flag");

   a_status_spare_bits: assert property (
      mls_rd |=> ((O_RDATA[15:5] == 11'h000) && (O_RDATA[3:1] == 3'h0)))
      else $error("modem status read shows bits outside its fields");

   c_tx_queue_full: cover property (q.ctrl.fifo_en && (q.tx_cnt == `UMS_FIFO_DEPTH));
   c_rx_queue_pop: cover property (rx_pop && q.ctrl.fifo_en);
   c_rx_overrun: cover property ($rose(q.overrun));
   c_loop_flag: cover property (q.ctrl.loop && $rose(q.peer_changed));
   c_frame_done: cover property ((q.tx_st == ums_pkg::UMS_TX_STOP) ##1 (q.tx_st == ums_pkg::UMS_TX_IDLE));

endmodule : ums_core

`default_nettype wire

// ---- sim/ums_peer_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// Serial peer: drives the peer ready pin and received characters, decodes frames.
module ums_peer_model (
   input wire logic i_clk,
   input wire logic i_tx,
   input wire logic i_ir_tx_b,
   output logic o_cts_b,
   output logic o_rx_stb,
   output logic [7:0] o_rx_data
);
   logic [7:0] frames[$];
   logic [7:0] sh;
   int ir_pulses;

   // The pin starts asserted so that it is held low across reset.
   initial begin
      o_cts_b = 1'h0;
      o_rx_stb = 1'h0;
      o_rx_data = 8'h00;
      ir_pulses = 0;
   end

   task automatic set_cts(input logic v);
      @(posedge i_clk);
      o_cts_b <= v;
      #1;
   endtask : set_cts

   // Data is inverted after the strobe so a stale byte never looks valid.
   task automatic send(input logic [7:0] d);
      @(posedge i_clk);
      o_rx_stb <= 1'h1;
      o_rx_data <= d;
      @(posedge i_clk);
      o_rx_stb <= 1'h0;
      o_rx_data <= ~d;
      #1;
   endtask : send

   // The start bit may be short, so samples sit just past each full bit time.
   initial begin
      forever begin
         @(negedge i_tx);
         repeat (891) @(posedge i_clk);
         for (int k = 0; k < 8; k++) begin
            sh[k] = i_tx;
            repeat (864) @(posedge i_clk);
         end
         if (i_tx === 1'h1) begin
            frames.push_back(sh);
         end
      end
   end

   // Each infrared pulse marks one zero bit.
   always @(negedge i_ir_tx_b) begin
      ir_pulses <= ir_pulses + 1;
   end
endmodule : ums_peer_model

`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ums_regs.svh"

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %0t got %0h expected %0h", $time, g, e); end end

module testbench;
   logic clk, rst_b, wr, rd, cts_b, rx_stb, tx, ir_tx_b, rts_b, rx_avail, tx_empty, fifo_en;
   logic [31:0] addr;
   logic [15:0] wdata, rdata;
   logic [7:0] rx_data;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   localparam logic [31:0] MS = `UMS_MODEM_LINE_STATUS_ADDR;
   localparam logic [31:0] SP = `UMS_SPARE_STORAGE_ADDR;
   localparam logic [31:0] CT = `UMS_MODEM_CONTROL_ADDR;
   localparam logic [31:0] LS = `UMS_LINE_STATUS_ADDR;

   ums_core ums_core_i (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd), .O_RDATA(rdata), .I_CTS_B(cts_b), .I_RX_STB(rx_stb), .I_RX_DATA(rx_data), .O_TX(tx),
      .O_IR_TX_B(ir_tx_b), .O_RTS_B(rts_b), .O_RX_AVAIL(rx_avail), .O_TX_EMPTY(tx_empty), .O_FIFO_EN(fifo_en));

   ums_peer_model ums_peer_model_i (.i_clk(clk), .i_tx(tx), .i_ir_tx_b(ir_tx_b), .o_cts_b(cts_b),
      .o_rx_stb(rx_stb), .o_rx_data(rx_data));

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   task automatic summarize();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   // Frames take thousands of cycles, so the ceiling leaves room for about seven.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         summarize();
      end
   end

   function automatic logic [31:0] al(input int k);
      return `UMS_ALIAS_FIRST_ADDR + 32'(4 * k);
   endfunction : al

   // Two idle cycles after a write let status flags settle before the next read.
   task automatic bwr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
   endtask : bwr

   task automatic brd(input logic [31:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      `CHK(rdata, e)
   endtask : brd

   task automatic wait_frames(input int n);
      int w;
      w = 0;
      while (ums_peer_model_i.frames.size() < n && w < 20000) begin
         @(posedge clk);
         w++;
      end
      #1;
   endtask : wait_frames

   task automatic t_reset();
      `CHK(tx, 1'h1)
      `CHK(ir_tx_b, 1'h1)
      `CHK(tx_empty, 1'h1)
      `CHK(rx_avail, 1'h0)
      `CHK(fifo_en, 1'h0)
      repeat (4) @(posedge clk);
      brd(MS, 16'h0011);
      brd(MS, 16'h0010);
      brd(SP, 16'h0000);
      brd(32'h5000_1170, 16'h0000);
   endtask : t_reset

   task automatic t_cts();
      ums_peer_model_i.set_cts(1'h1);
      repeat (4) @(posedge clk);
      brd(MS, 16'h0001);
      brd(MS, 16'h0000);
   endtask : t_cts

   // The pin is high on entry, so only the control bit can move the status.
   task automatic t_loop();
      bwr(CT, 16'h0010);
      brd(MS, 16'h0000);
      bwr(CT, 16'h0012);
      brd(MS, 16'h0011);
      ums_peer_model_i.set_cts(1'h0);
      repeat (4) @(posedge clk);
      brd(MS, 16'h0010);
      bwr(CT, 16'h0010);
      brd(MS, 16'h0001);
      bwr(CT, 16'h0000);
      brd(MS, 16'h0011);
   endtask : t_loop

   task automatic t_spare();
      bwr(SP, 16'h00A5);
      brd(SP, 16'h00A5);
      bwr(SP, 16'hFF5A);
      brd(SP, 16'h005A);
      brd(MS, 16'h0010);
   endtask : t_spare

   task automatic t_rx();
      int i;
      ums_peer_model_i.send(8'h11);
      `CHK(rx_avail, 1'h1)
      ums_peer_model_i.send(8'h22);
      brd(al(5), 16'h0022);
      `CHK(rx_avail, 1'h0)
      brd(LS, 16'h0062);
      bwr(CT, 16'h0001);
      `CHK(fifo_en, 1'h1)
      for (i = 0; i < 17; i++) ums_peer_model_i.send(8'h80 + 8'(i));
      brd(LS, 16'h0063);
      for (i = 0; i < 16; i++) brd(al(i), 16'h0080 + 16'(i));
      `CHK(rx_avail, 1'h0)
   endtask : t_rx

   // The first byte leaves at once; the second waits and is then replaced.
   task automatic t_tx_single();
      bwr(CT, 16'h0000);
      bwr(al(0), 16'h0001);
      bwr(al(1), 16'h0055);
      `CHK(tx_empty, 1'h0)
      bwr(al(2), 16'h00A6);
      wait_frames(2);
      `CHK(ums_peer_model_i.frames[0], 8'h01)
      `CHK(ums_peer_model_i.frames[1], 8'hA6)
      ums_peer_model_i.frames.delete();
   endtask : t_tx_single

   task automatic t_tx_fifo();
      int i;
      // The last stop bit may still run for most of a bit time after the frame is logged.
      repeat (900) @(posedge clk);
      brd(LS, 16'h0060);
      bwr(CT, 16'h0001);
      for (i = 0; i < 16; i++) bwr(al(i), 16'h0040 + 16'(i));
      brd(LS, 16'h0000);
      bwr(al(0), 16'h0050);
      brd(LS, 16'h0080);
      bwr(al(1), 16'h0051);
      brd(LS, 16'h0080);
      bwr(CT, 16'h0000);
      wait_frames(1);
      `CHK(ums_peer_model_i.frames[0], 8'h40)
      repeat (600) @(posedge clk);
   endtask : t_tx_fifo

   // Byte 0x0F carries four zero bits plus the start bit.
   task automatic t_ir();
      int low;
      int p0;
      low = 0;
      bwr(CT, 16'h0040);
      p0 = ums_peer_model_i.ir_pulses;
      bwr(al(0), 16'h000F);
      repeat (9000) begin
         @(posedge clk);
         if (tx !== 1'h1) low++;
      end
      `CHK(low, 0)
      `CHK(ums_peer_model_i.ir_pulses - p0, 5)
   endtask : t_ir

   // Reset is held for five cycles and released on a rising edge.
   initial begin
      rst_b = 1'h0;
      addr = 32'h0000_0000;
      wdata = 16'h0000;
      wr = 1'h0;
      rd = 1'h0;
      repeat (5) @(posedge clk);
      rst_b <= 1'h1;
      #1;
      t_reset();
      t_cts();
      t_loop();
      t_spare();
      t_rx();
      t_tx_single();
      t_tx_fifo();
      t_ir();
      summarize();
   end
endmodule : testbench

`default_nettype wire
